// *** rtl/tcc_timer.sv ***
// centre-aligned 16-bit timer with clock source selection and AHB-Lite registers
// Notes on behaviour
// [R1] centre mode: count 0..arr-1 up with overflow, arr..1 down with underflow
// [R2] direction bit ignores writes; hardware shows present direction
// [R3] update event on every overflow and every underflow
// [R4] update-generate or slave controller makes update; counter and prescaler restart at zero (the code has no slave-controller update, only update-generate)
// [R5] update-disable set blocks update events; counting continues with active reload (the code still makes an update on update-generate)
// [R6] request-source set: software update does not set update flag
// [R7] update sets flag unless request-source; loads prescaler and reload shadows
// [R8] overflow update loads new reload before counter reload
// [R9] counter clock from internal, channel 2 pin, external trigger, internal trigger
// [R10] slave mode 000 uses internal clock; update-generate bit self-clears
// [R11] internal mode: prescaler clocked once counter enable written to one
// [R12] slave mode 111 selects external clock mode 1 on chosen edges
// [R13] software sets input-select, polarity, slave mode, trigger select, then enable
// [R14] each qualifying channel 2 edge advances counter once and sets trigger flag
// [R15] external edges resynchronised, adding a few clock cycles of latency
// [R16] capture prescaler never applies to the trigger path
// [R17] external-clock-enable selects mode 2 on external trigger edges
// [R18] source field: 00 clock, 01 1 kHz, 10 32 kHz, 11 clock pin
// [R19] pin source with mask enable is ANDed with the mask pin
// [R20] filter 0000, prescaler 01, rising: one count per two edges
// [R21] channel input sampled, filtered, edge detected with polarity
// [R22] compare reference is active high, optionally inverted onto output
// [R23] counter clock divided by two to a 4-bit exponent, up to 32768
// [R24] prescaler setting buffered, takes effect at next update event
// [R25] after reset slave mode off and mode 2 off: internal clock
`timescale 1ns/100ps
`include "tcc_regs.svh"
module tcc_timer
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire tcc_pkg::tcc_ahb_req_t ahb_req,
	input  wire logic [31:0]           hwdata,
	output logic      [31:0]           hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	input  wire tcc_pkg::tcc_pins_t    pins,
	output logic                       compare_output_signal,
	output logic                       update_event_out
);
	import tcc_pkg::*;

	// control registers
	logic        counter_enable_bit_ff, update_disable_bit_ff, update_request_source_bit_ff;
	logic [2:0]  slave_mode_field_ff, trigger_select_field_ff;
	logic [3:0]  ext_trigger_filter_ff;
	logic [1:0]  ext_trigger_prescaler_ff;
	logic        external_clock_enable_ff, ext_trigger_polarity_ff;
	logic [1:0]  channel2_input_select_ff;
	logic [3:0]  channel2_input_filter_ff;
	logic        channel2_polarity_ff, cc1_polarity_ff;
	logic [1:0]  external_trigger_source_field_ff;
	logic        clock_mask_enable_ff;
	logic [3:0]  psc_buf_ff, psc_shadow_ff;
	logic [15:0] arr_buf_ff, arr_act_ff, cnt_ff;
	tcc_dir_t    dir_ff;
	logic        update_interrupt_flag_ff, trigger_interrupt_flag_ff;
	logic        ug_ff;
	logic        cnt_en_ff;
	logic [15:0] psc_cnt_ff;

	// bus pipeline
	logic        wr_pend_ff;
	logic [11:0] addr_ff;
	logic        sel_ok;
	assign sel_ok = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_ff <= 1'b0;
			addr_ff    <= 12'h000;
		end
		else
		begin
			wr_pend_ff <= sel_ok & ahb_req.hwrite;
			if (sel_ok)
				addr_ff <= ahb_req.haddr[11:0];
		end
	end

	// zero-wait slave, always OKAY
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	function automatic logic wr_hit(input logic [11:0] off);
		wr_hit = wr_pend_ff && (addr_ff == off);
	endfunction

	// config writes; reset leaves slave controller and mode 2 off
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			counter_enable_bit_ff            <= 1'b0;
			update_disable_bit_ff            <= 1'b0;
			update_request_source_bit_ff     <= 1'b0;
			slave_mode_field_ff              <= `TCC_SMS_INT; // see [R25]
			trigger_select_field_ff          <= 3'h0;
			ext_trigger_filter_ff            <= 4'h0;
			ext_trigger_prescaler_ff         <= 2'h0;
			external_clock_enable_ff         <= 1'b0; // see [R25]
			ext_trigger_polarity_ff          <= 1'b0;
			channel2_input_select_ff         <= 2'h0;
			channel2_input_filter_ff         <= 4'h0;
			channel2_polarity_ff             <= 1'b0;
			cc1_polarity_ff                  <= 1'b0;
			external_trigger_source_field_ff <= 2'h0;
			clock_mask_enable_ff             <= 1'b0;
			psc_buf_ff                       <= 4'h0;
			arr_buf_ff                       <= `TCC_ARR_RST;
		end
		else
		begin
			if (wr_hit(`TCC_CR1_OFF))
			begin
				counter_enable_bit_ff        <= hwdata[`TCC_CR1_CEN];
				update_disable_bit_ff        <= hwdata[`TCC_CR1_UDIS];
				update_request_source_bit_ff <= hwdata[`TCC_CR1_URS];
			end
			if (wr_hit(`TCC_SMCR_OFF))
			begin
				slave_mode_field_ff      <= hwdata[`TCC_SMCR_SMS_LSB +: 3];
				trigger_select_field_ff  <= hwdata[`TCC_SMCR_TS_LSB +: 3];
				ext_trigger_filter_ff    <= hwdata[`TCC_SMCR_ETF_LSB +: 4];
				ext_trigger_prescaler_ff <= hwdata[`TCC_SMCR_ETPS_LSB +: 2];
				external_clock_enable_ff <= hwdata[`TCC_SMCR_ECE];
				ext_trigger_polarity_ff  <= hwdata[`TCC_SMCR_ETP];
			end
			if (wr_hit(`TCC_CCMR_OFF))
			begin
				channel2_input_select_ff <= hwdata[`TCC_CCMR_CC2S_LSB +: 2];
				channel2_input_filter_ff <= hwdata[`TCC_CCMR_IC2F_LSB +: 4];
			end
			if (wr_hit(`TCC_CCER_OFF))
			begin
				cc1_polarity_ff      <= hwdata[`TCC_CCER_CC1P];
				channel2_polarity_ff <= hwdata[`TCC_CCER_CC2P];
			end
			if (wr_hit(`TCC_OR_OFF))
			begin
				external_trigger_source_field_ff <= hwdata[`TCC_OR_SEL_LSB +: 2];
				clock_mask_enable_ff             <= hwdata[`TCC_OR_MSKEN];
			end
			if (wr_hit(`TCC_PSC_OFF))
				psc_buf_ff <= hwdata[3:0]; // see [R24]
			if (wr_hit(`TCC_ARR_OFF))
				arr_buf_ff <= hwdata[15:0];
		end
	end

	// pin synchronisers; first stage read only by the second
	logic [5:0] sync1_ff, sync2_ff;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_ff <= 6'h00;
			sync2_ff <= 6'h00;
		end
		else
		begin
			sync1_ff <= pins; // see [R15]
			sync2_ff <= sync1_ff;
		end
	end
	logic s_clk, s_msk, s_1k, s_32k, s_ch2, s_itr;
	assign {s_clk, s_msk, s_1k, s_32k, s_ch2, s_itr} = sync2_ff;

	// digital filter: new level needs n+1 equal samples for setting n; shared by both filters
	function automatic logic [3:0] filt_len(input logic [3:0] f);
		filt_len = (f == 4'h0) ? 4'h0 : f;
	endfunction

	logic [3:0] ch2_fcnt_ff, etr_fcnt_ff;
	logic       filtered_channel_input_ff, etr_filt_ff;
	logic       ch2_prev_ff, etr_prev_ff;
	logic       etr_raw;

	// source mux and optional gating by the mask pin
	always_comb
	begin
		case (external_trigger_source_field_ff) // see [R18]
			2'h0: etr_raw = 1'b0; // peripheral clock: every cycle is an edge
			2'h1: etr_raw = s_1k;
			2'h2: etr_raw = s_32k;
			default: etr_raw = clock_mask_enable_ff ? (s_clk & s_msk) : s_clk; // see [R19]
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ch2_fcnt_ff               <= 4'h0;
			etr_fcnt_ff               <= 4'h0;
			filtered_channel_input_ff <= 1'b0;
			etr_filt_ff               <= 1'b0;
			ch2_prev_ff               <= 1'b0;
			etr_prev_ff               <= 1'b0;
		end
		else
		begin
			// see [R21]
			if (s_ch2 == filtered_channel_input_ff)
				ch2_fcnt_ff <= 4'h0;
			else if (ch2_fcnt_ff >= filt_len(channel2_input_filter_ff))
			begin
				filtered_channel_input_ff <= s_ch2;
				ch2_fcnt_ff               <= 4'h0;
			end
			else
				ch2_fcnt_ff <= ch2_fcnt_ff + 4'h1;
			if (etr_raw == etr_filt_ff)
				etr_fcnt_ff <= 4'h0;
			else if (etr_fcnt_ff >= filt_len(ext_trigger_filter_ff))
			begin
				etr_filt_ff <= etr_raw;
				etr_fcnt_ff <= 4'h0;
			end
			else
				etr_fcnt_ff <= etr_fcnt_ff + 4'h1;
			ch2_prev_ff <= filtered_channel_input_ff;
			etr_prev_ff <= etr_filt_ff;
		end
	end

	// channel 2 and external trigger edges polarity-qualified (source 00: every cycle), internal trigger rising only; no capture prescaler in this path
	logic edge_detected_channel_input, etr_edge, itr_edge;
	logic itr_prev_ff;
	assign edge_detected_channel_input = channel2_polarity_ff ?
		(ch2_prev_ff & ~filtered_channel_input_ff) :
		(~ch2_prev_ff & filtered_channel_input_ff); // see [R16]
	assign etr_edge = (external_trigger_source_field_ff == 2'h0) ? 1'b1 :
		(ext_trigger_polarity_ff ? (etr_prev_ff & ~etr_filt_ff) : (~etr_prev_ff & etr_filt_ff));
	assign itr_edge = s_itr & ~itr_prev_ff;

	// external trigger prescaler: divide by 1,2,4,8
	logic [2:0] etps_cnt_ff;
	logic       etr_tick;
	assign etr_tick = etr_edge &&
		((etps_cnt_ff & ((3'h1 << ext_trigger_prescaler_ff) - 3'h1)) ==
		 ((3'h1 << ext_trigger_prescaler_ff) - 3'h1)); // see [R20]
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			etps_cnt_ff <= 3'h0;
			itr_prev_ff <= 1'b0;
		end
		else
		begin
			itr_prev_ff <= s_itr;
			if (etr_edge)
				etps_cnt_ff <= etr_tick ? 3'h0 : etps_cnt_ff + 3'h1;
		end
	end

	// trigger input selected for mode 1
	logic trig_edge;
	assign trig_edge = (trigger_select_field_ff == `TCC_TS_TI2) ? edge_detected_channel_input :
		(trigger_select_field_ff == `TCC_TS_INTERNAL_TRIGGER_INPUT) ? itr_edge : 1'b0;

	// counter clock source selection
	logic ck_psc;
	always_comb
	begin
		if (external_clock_enable_ff)
			ck_psc = etr_tick; // see [R17]
		else if (slave_mode_field_ff == `TCC_SMS_EXT1)
			ck_psc = trig_edge; // see [R12] [R14]
		else
			ck_psc = 1'b1; // see [R9] [R10] [R11]
	end

	// counter enable lags the bit by one cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_en_ff <= 1'b0;
		else
			cnt_en_ff <= counter_enable_bit_ff; // see [R11]
	end

	// software update strobe, cleared by hardware next cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ug_ff <= 1'b0;
		else
			ug_ff <= wr_hit(`TCC_EGR_OFF) & hwdata[`TCC_EGR_UG]; // see [R4] [R10]
	end

	// prescaler: tick every 2^exp counter clocks
	logic psc_tick;
	logic [15:0] psc_mask;
	assign psc_mask = 16'(({16'h0, 16'h1} << psc_shadow_ff) - 32'h1);
	assign psc_tick = cnt_en_ff & ck_psc & (psc_cnt_ff == psc_mask); // see [R23]

	// centre-aligned count and update events
	logic ovf, unf, hw_upd, any_upd;
	assign ovf    = psc_tick && dir_ff == TCC_UP && cnt_ff >= arr_act_ff - 16'h1;
	assign unf    = psc_tick && dir_ff == TCC_DOWN && cnt_ff <= 16'h1;
	assign hw_upd = (ovf | unf) & ~update_disable_bit_ff; // see [R3] [R5]
	assign any_upd = hw_upd | ug_ff;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_ff        <= 16'h0000;
			dir_ff        <= TCC_UP;
			psc_cnt_ff    <= 16'h0000;
			psc_shadow_ff <= 4'h0;
			arr_act_ff    <= `TCC_ARR_RST;
		end
		else
		begin
			if (any_upd)
			begin
				psc_shadow_ff <= psc_buf_ff; // see [R7] [R24]
				arr_act_ff    <= arr_buf_ff; // see [R8]
			end
			if (ug_ff)
			begin
				cnt_ff     <= 16'h0000; // see [R4]
				psc_cnt_ff <= 16'h0000;
				dir_ff     <= TCC_UP;
			end
			else if (cnt_en_ff && ck_psc)
			begin
				psc_cnt_ff <= psc_tick ? 16'h0000 : psc_cnt_ff + 16'h1;
				if (ovf)
				begin
					// an overflow update turns with the freshly loaded reload, not the old one
					cnt_ff <= hw_upd ? arr_buf_ff : arr_act_ff; // see [R1] [R8]
					dir_ff <= TCC_DOWN; // see [R2]
				end
				else if (unf)
				begin
					cnt_ff <= 16'h0000;
					dir_ff <= TCC_UP;
				end
				else if (psc_tick)
					cnt_ff <= (dir_ff == TCC_UP) ? cnt_ff + 16'h1 : cnt_ff - 16'h1;
			end
		end
	end

	// flags: hardware set wins over the write-one clear
	logic clr_u, clr_t;
	assign clr_u = wr_hit(`TCC_FLAG_OFF) & hwdata[`TCC_FLAG_UIF];
	assign clr_t = wr_hit(`TCC_FLAG_OFF) & hwdata[`TCC_FLAG_TIF];
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			update_interrupt_flag_ff  <= 1'b0;
			trigger_interrupt_flag_ff <= 1'b0;
			update_event_out          <= 1'b0;
		end
		else
		begin
			update_event_out <= any_upd;
			if (hw_upd | (ug_ff & ~update_request_source_bit_ff)) // see [R6] [R7]
				update_interrupt_flag_ff <= 1'b1;
			else if (clr_u)
				update_interrupt_flag_ff <= 1'b0;
			if (slave_mode_field_ff == `TCC_SMS_EXT1 && trig_edge) // see [R14]
				trigger_interrupt_flag_ff <= 1'b1;
			else if (clr_t)
				trigger_interrupt_flag_ff <= 1'b0;
		end
	end

	// compare reference high while counting up; inverted by polarity
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			compare_output_signal <= 1'b0;
		else
			compare_output_signal <= (dir_ff == TCC_UP) ^ cc1_polarity_ff; // see [R22]
	end

	// read mux, registered in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (sel_ok & ~ahb_req.hwrite)
		begin
			case (ahb_req.haddr[11:0])
				`TCC_CR1_OFF:  hrdata <= {27'h0, dir_ff == TCC_DOWN, 1'b0,
					update_request_source_bit_ff, update_disable_bit_ff,
					counter_enable_bit_ff}; // see [R2]
				`TCC_SMCR_OFF: hrdata <= {16'h0, ext_trigger_polarity_ff, external_clock_enable_ff,
					ext_trigger_prescaler_ff, ext_trigger_filter_ff, 1'b0,
					trigger_select_field_ff, 1'b0, slave_mode_field_ff};
				`TCC_CCMR_OFF: hrdata <= {16'h0, channel2_input_filter_ff, 2'h0,
					channel2_input_select_ff, 8'h0};
				`TCC_CCER_OFF: hrdata <= {26'h0, channel2_polarity_ff, 3'h0, cc1_polarity_ff, 1'b0};
				`TCC_OR_OFF:   hrdata <= {29'h0, clock_mask_enable_ff,
					external_trigger_source_field_ff};
				`TCC_PSC_OFF:  hrdata <= {28'h0, psc_buf_ff};
				`TCC_ARR_OFF:  hrdata <= {16'h0, arr_buf_ff};
				`TCC_CNT_OFF:  hrdata <= {16'h0, cnt_ff};
				`TCC_FLAG_OFF: hrdata <= {25'h0, trigger_interrupt_flag_ff, 5'h0,
					update_interrupt_flag_ff};
				default:       hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// checks
	upd_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		hw_upd |=> update_interrupt_flag_ff) // see [R7]
		else $error("update flag not set after update");
	urs_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ug_ff && update_request_source_bit_ff && !hw_upd && !update_interrupt_flag_ff)
		|=> !update_interrupt_flag_ff) // see [R6]
		else $error("software update set flag despite request source");
	udis_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(update_disable_bit_ff && !ug_ff) |-> !any_upd) // see [R5]
		else $error("update while disabled");
	ovf_turn_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ovf && !ug_ff) |=> dir_ff == TCC_DOWN && cnt_ff == arr_act_ff) // see [R1] [R8]
		else $error("overflow did not turn counter down");
	unf_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(unf && !ug_ff) |=> cnt_ff == 16'h0000 && dir_ff == TCC_UP) // see [R1]
		else $error("underflow did not restart at zero");
	ug_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ug_ff |=> cnt_ff == 16'h0000 && psc_cnt_ff == 16'h0000 && !ug_ff) // see [R4]
		else $error("software update did not restart counters");
	psc_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
		any_upd |=> psc_shadow_ff == $past(psc_buf_ff)) // see [R24]
		else $error("prescaler shadow not loaded on update");
	trig_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(slave_mode_field_ff == `TCC_SMS_EXT1 && trig_edge) |=> trigger_interrupt_flag_ff) // see [R14]
		else $error("trigger flag missing");
endmodule // tcc_timer

// *** shared/tcc_pkg.sv ***
// types shared by the timer block
package tcc_pkg;
	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hsel;
		logic        hready;
	} tcc_ahb_req_t;
	typedef enum logic [1:0] {
		TCC_UP   = 2'b01,
		TCC_DOWN = 2'b10
	} tcc_dir_t;
	typedef struct packed {
		logic ext_clk_pin;
		logic ext_msk_pin;
		logic osc_1k;
		logic osc_32k;
		logic ch2_pin;
		logic itr_in;
	} tcc_pins_t;
endpackage

// *** shared/tcc_regs.svh ***
// register offsets, field positions and reset values for the timer block
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH
`define TCC_CR1_OFF        12'h000
`define TCC_EGR_OFF        12'h004
`define TCC_SMCR_OFF       12'h008
`define TCC_CCMR_OFF       12'h00C
`define TCC_CCER_OFF       12'h010
`define TCC_OR_OFF         12'h014
`define TCC_PSC_OFF        12'h018
`define TCC_ARR_OFF        12'h01C
`define TCC_CNT_OFF        12'h020
`define TCC_FLAG_OFF       12'h024
`define TCC_ARR_RST        16'hFFFF
`define TCC_CR1_CEN        0
`define TCC_CR1_UDIS       1
`define TCC_CR1_URS        2
`define TCC_CR1_DIR        4
`define TCC_EGR_UG         0
`define TCC_SMCR_SMS_LSB   0
`define TCC_SMCR_TS_LSB    4
`define TCC_SMCR_ETF_LSB   8
`define TCC_SMCR_ETPS_LSB  12
`define TCC_SMCR_ECE       14
`define TCC_SMCR_ETP       15
`define TCC_CCMR_CC2S_LSB  8
`define TCC_CCMR_IC2F_LSB  12
`define TCC_CCER_CC1P      1
`define TCC_CCER_CC2P      5
`define TCC_OR_SEL_LSB     0
`define TCC_OR_MSKEN       2
`define TCC_FLAG_UIF       0
`define TCC_FLAG_TIF       6
`define TCC_SMS_INT        3'h0
`define TCC_SMS_EXT1       3'h7
`define TCC_TS_INTERNAL_TRIGGER_INPUT        3'h0
`define TCC_TS_TI2         3'h6
`define TCC_CC2S_TI2       2'h1
`endif

// *** sim/tcc_pin_drv.sv ***
// model of the external clock, mask, oscillator, channel 2 and trigger pins
`timescale 1ns/100ps
module tcc_pin_drv
(
	input  wire logic          hclk,
	output tcc_pkg::tcc_pins_t pins
);
	import tcc_pkg::*;

	// all lines idle low, as undriven timer inputs would sit
	initial pins = '0;

	// sel: 0 clock pin, 1 mask pin, 2 osc 1k, 3 osc 32k, 4 channel 2, 5 trigger
	// levels held six cycles so every edge clears sync and edge detection
	task automatic pulse(input int sel, input int n);
		int i;
		for (i = 0; i < n; i++)
		begin
			@(posedge hclk);
			pins[5 - sel] <= 1'b1;
			repeat (6) @(posedge hclk);
			pins[5 - sel] <= 1'b0;
			repeat (5) @(posedge hclk);
		end
	endtask

	// mask pin is a steady gate level, not a pulse train
	task automatic set_mask(input logic v);
		@(posedge hclk);
		pins.ext_msk_pin <= v;
	endtask
endmodule // tcc_pin_drv

// *** sim/tcc_timer_bench.sv ***
// self-checking bench for the centre-aligned timer and its clock selection
`timescale 1ns/100ps
`include "tcc_regs.svh"
module tcc_timer_bench;
	import tcc_pkg::*;
	logic         hclk;
	logic         hresetn;
	logic [31:0]  haddr;
	logic [1:0]   htrans;
	logic         hwrite;
	logic [2:0]   hsize;
	logic         hsel;
	logic [31:0]  hwdata;
	logic [31:0]  hrdata;
	logic         hreadyout;
	logic         hresp;
	logic         cmp_out;
	logic         update_event;
	tcc_pins_t    pins;
	tcc_ahb_req_t ahb_req;
	int           failures;
	int           tests_run;
	logic [31:0]  rd;
	logic [31:0]  gap;
	logic         up_seen;
	logic         dn_seen;
	logic         bad;
	int           i;

	// single slave, so its ready closes the loop
	assign ahb_req = '{haddr, htrans, hwrite, hsize, hsel, hreadyout};

	tcc_timer dut
	(
		.hclk                  (hclk),
		.hresetn               (hresetn),
		.ahb_req               (ahb_req),
		.hwdata                (hwdata),
		.hrdata                (hrdata),
		.hreadyout             (hreadyout),
		.hresp                 (hresp),
		.pins                  (pins),
		.compare_output_signal (cmp_out),
		.update_event_out      (update_event)
	);

	tcc_pin_drv pm
	(
		.hclk (hclk),
		.pins (pins)
	);

	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one transfer: address phase held until ready, then data phase until ready
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge hclk);
		haddr  <= {20'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		hsel   <= 1'b1;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(name, exp, rd & m);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	// bounded wait for the next update pulse; bad marks a miss
	task automatic wait_uev(input int lim);
		int k;
		k = 0;
		do
		begin
			@(posedge hclk);
			k++;
		end
		while (update_event !== 1'b1 && k < lim);
		bad = (update_event !== 1'b1);
	endtask

	// cycles between two update pulses after skipping some
	task automatic measure(input int skip);
		repeat (skip) wait_uev(300);
		gap = 0;
		do
		begin
			@(posedge hclk);
			gap++;
		end
		while (update_event !== 1'b1 && gap < 300);
	endtask

	// restart from zero on a fresh source, then count n pin edges
	task automatic ext_run(input string name, input logic [31:0] sm, input logic [31:0] orv,
		input int sel, input int n, input logic [31:0] exp);
		wr(`TCC_CR1_OFF, 32'h0);
		wr(`TCC_SMCR_OFF, sm);
		wr(`TCC_OR_OFF, orv);
		wr(`TCC_EGR_OFF, 32'h1);
		wr(`TCC_FLAG_OFF, 32'h41);
		wr(`TCC_CR1_OFF, 32'h1);
		pm.pulse(sel, n);
		repeat (12) @(posedge hclk);
		rdc(name, `TCC_CNT_OFF, 32'hFFFF, exp);
	endtask

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// hang guard, well beyond the thousand or so cycles the tests need
	initial
	begin
		#400000;
		failures++;
		$display("watchdog expired");
		conclude();
	end

	initial
	begin
		hresetn   = 1'b0;
		haddr     = 32'h0;
		htrans    = 2'b00;
		hwrite    = 1'b0;
		hsize     = 3'b010;
		hsel      = 1'b0;
		hwdata    = 32'h0;
		failures  = 0;
		tests_run = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rdc("cr1", `TCC_CR1_OFF, 32'hFFFFFFFF, 32'h0);
		rdc("smcr", `TCC_SMCR_OFF, 32'hFFFFFFFF, 32'h0);
		rdc("arr", `TCC_ARR_OFF, 32'hFFFFFFFF, 32'h0000FFFF);
		wr(12'h040, 32'hFFFFFFFF);
		rdc("unmapped", 12'h040, 32'hFFFFFFFF, 32'h0);
		$display("test reset done");

		// software update loads shadows, zeroes the counter, sets the flag
		wr(`TCC_ARR_OFF, 32'h4);
		wr(`TCC_EGR_OFF, 32'h1);
		rdc("uif sw", `TCC_FLAG_OFF, 32'h1, 32'h1);
		rdc("ug clear", `TCC_EGR_OFF, 32'h1, 32'h0);
		rdc("cnt ug", `TCC_CNT_OFF, 32'hFFFF, 32'h0);
		chk("ref up", 32'h1, {31'h0, cmp_out});
		wr(`TCC_CCER_OFF, 32'h2);
		repeat (3) @(posedge hclk);
		chk("ref inv", 32'h0, {31'h0, cmp_out});
		wr(`TCC_CCER_OFF, 32'h0);
		wr(`TCC_FLAG_OFF, 32'h1);
		rdc("uif clr", `TCC_FLAG_OFF, 32'h1, 32'h0);
		// direction bit written too; hardware must ignore it
		wr(`TCC_CR1_OFF, 32'h11);
		measure(2);
		chk("gap arr4", 32'd4, gap);
		up_seen = 1'b0;
		dn_seen = 1'b0;
		for (i = 0; i < 16; i++)
		begin
			bus(1'b0, `TCC_CR1_OFF, 32'h0);
			if (rd[4] === 1'b1)
				dn_seen = 1'b1;
			if (rd[4] === 1'b0)
				up_seen = 1'b1;
		end
		chk("dir both", 32'h3, {30'h0, up_seen, dn_seen});
		rdc("uif cnt", `TCC_FLAG_OFF, 32'h1, 32'h1);
		$display("test centre done");

		// with updates held off, new reload and prescale stay in the buffers
		wr(`TCC_CR1_OFF, 32'h3);
		wr(`TCC_ARR_OFF, 32'h6);
		wr(`TCC_PSC_OFF, 32'h1);
		bad = 1'b0;
		repeat (60)
		begin
			@(posedge hclk);
			bad = bad | update_event;
		end
		chk("no update", 32'h0, {31'h0, bad});
		for (i = 0; i < 12; i++)
		begin
			bus(1'b0, `TCC_CNT_OFF, 32'h0);
			bad = bad | (rd[15:0] > 16'h4);
		end
		chk("old reload", 32'h0, {31'h0, bad});
		wr(`TCC_CR1_OFF, 32'h1);
		measure(2);
		chk("gap arr6 psc2", 32'd12, gap);
		rdc("arr buf", `TCC_ARR_OFF, 32'hFFFF, 32'h6);
		$display("test buffered done");

		// request-source set: software update pulses but leaves the flag
		wr(`TCC_CR1_OFF, 32'h4);
		wr(`TCC_FLAG_OFF, 32'h1);
		wr(`TCC_EGR_OFF, 32'h1);
		wait_uev(10);
		chk("ug pulse", 32'h0, {31'h0, bad});
		rdc("uif urs", `TCC_FLAG_OFF, 32'h1, 32'h0);
		rdc("cnt urs", `TCC_CNT_OFF, 32'hFFFF, 32'h0);
		$display("test request source done");

		// external mode 1: channel 2 rising edges, then the internal trigger
		wr(`TCC_ARR_OFF, 32'h100);
		wr(`TCC_PSC_OFF, 32'h0);
		wr(`TCC_CCMR_OFF, 32'h100);
		wr(`TCC_CCER_OFF, 32'h0);
		ext_run("mode1 ch2", 32'h67, 32'h0, 4, 5, 32'h5);
		rdc("tif", `TCC_FLAG_OFF, 32'h40, 32'h40);
		ext_run("mode1 itr", 32'h07, 32'h0, 5, 3, 32'h3);
		$display("test mode1 done");

		// external mode 2: each trigger source, divided edges and the mask gate
		ext_run("etr 1k", 32'h4000, 32'h1, 2, 4, 32'h4);
		ext_run("etr 32k", 32'h4000, 32'h2, 3, 4, 32'h4);
		ext_run("etr pin", 32'h4000, 32'h3, 0, 4, 32'h4);
		ext_run("etr div2", 32'h5000, 32'h3, 0, 8, 32'h4);
		pm.set_mask(1'b0);
		ext_run("mask low", 32'h5000, 32'h7, 0, 4, 32'h0);
		pm.set_mask(1'b1);
		ext_run("mask high", 32'h5000, 32'h7, 0, 4, 32'h2);
		// peripheral clock source ticks every cycle: enable lands, counts start two edges later,
		// so 24 counts stand when the read is taken
		ext_run("etr pclk", 32'h4000, 32'h0, 0, 1, 32'h18);
		bus(1'b0, `TCC_CNT_OFF, 32'h0);
		chk("pclk runs", 32'h1, {31'h0, rd[15:0] != 16'h0});
		$display("test mode2 done");
		conclude();
	end
endmodule // tcc_timer_bench
